/* File: rtl/serial_clock_prescaler_select.sv */
// Behaviour
// - reset loads the clock select register with 88H, both nibbles at code 1000.
// - low nibble picks channel 0 clock; i2c and 2/3-wire use different divisor sets.
// - high nibble picks channel 1 clock, fxx/2 to fxx/2^8 for codes 0110-1101.
// - fxx is fx with full-rate bit set, else fx/2; code 0110 banned then.
// - busy enable sits at bit 7 of the serial bus control register.
// - ack auto enable sits at bit 5 of the serial bus control register.
// - channel 0 internal clock goes out on o_clk and drives serial clock pin.
`timescale 1ns/100ps
module serial_clock_prescaler_select (
	input  wire logic                                     i_clk_sys,
	input  wire logic                                     i_rstn,
	input  wire logic                                     i_ce,
	input  wire logic [15:0]                              i_addr,
	input  wire logic                                     i_wr,
	input  wire logic                                     i_rd,
	input  wire logic [7:0]                               i_wdata,
	input  wire logic [7:0]                               i_oscillator_mode_reg,
	input  wire logic [7:0]                               i_serial_bus_ctrl_reg,
	input  wire serial_clock_prescaler_select_pkg::ch0_mode_e i_ch0_mode,
	input  wire logic                                     i_ch0_internal_clk,
	output logic [7:0]                                    o_rdata,
	output logic                                          o_rd_hit,
	output serial_clock_prescaler_select_pkg::clk_out_s   o_clk,
	output logic                                          o_sck0,
	output logic                                          o_sck0_oen_n,
	output logic                                          o_busy_enable,
	output logic                                          o_ack_auto_enable,
	output logic                                          o_ch0_prohibited,
	output logic                                          o_ch1_prohibited
);
	import serial_clock_prescaler_select_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// code is legal and, at full rate, not the banned lowest code
	function automatic logic code_ok(input logic [3:0] code, input logic full);
		code_ok = (code >= SEL_CODE_MIN) && (code <= SEL_CODE_MAX)
			&& !(full && (code == SEL_CODE_MIN));
	endfunction

	// address decode shared by read and write paths
	function automatic logic addr_hit(input logic [15:0] addr);
		addr_hit = (addr == SERIAL_CLOCK_SELECT_ADDR);
	endfunction

	// exponent n of fxx/2^n for the 2/3-wire style table
	function automatic logic [3:0] code_exp(input logic [3:0] code);
		code_exp = code - CODE_TO_EXP_OFS;
	endfunction

	clk_sel_s         sel_ff;
	logic             fxx_en;
	logic             half_ff;
	logic [PRESC_W:0] presc_ff;
	logic [PRESC_W:0] presc_prev_ff;
	logic             full_rate;
	logic [3:0]       exp0;
	logic [3:0]       exp1;
	logic             ok0;
	logic             ok1;
	clk_out_s         nxt_clk;
	clk_out_s         clk_ff;
	logic             wr_sel;
	logic             rd_sel;

	assign full_rate = i_oscillator_mode_reg[OSC_FULL_RATE_BIT];
	assign wr_sel    = i_wr && addr_hit(i_addr);
	assign rd_sel    = i_rd && addr_hit(i_addr);

	// ----------------------------------------------------------------
	// register
	// ----------------------------------------------------------------
	// reset value 88H
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			sel_ff <= clk_sel_s'(SERIAL_CLOCK_SELECT_RST);
		end else if (i_ce && wr_sel) begin
			sel_ff <= clk_sel_s'(i_wdata);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata  <= 8'h00;
			o_rd_hit <= 1'b0;
		end else if (i_ce) begin
			o_rd_hit <= rd_sel;
			// zero when idle so a stale byte never looks like an answer
			o_rdata  <= rd_sel ? sel_ff : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------
	// fxx base: every clock, or every second one
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			half_ff <= 1'b0;
		end else if (i_ce) begin
			half_ff <= ~half_ff;
		end
	end
	assign fxx_en = full_rate | half_ff;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			presc_ff      <= '0;
			presc_prev_ff <= '0;
		end else if (i_ce && fxx_en) begin
			presc_ff      <= presc_ff + 1'b1;
			presc_prev_ff <= presc_ff;
		end
	end

	// ----------------------------------------------------------------
	// selection
	// ----------------------------------------------------------------
	logic [1:0][3:0] sel_code;
	logic [1:0][3:0] sel_exp;
	logic [1:0]      sel_ok;
	logic [1:0]      tap_now;
	logic [1:0]      tap_prev;
	logic [1:0]      clk_lvl;
	logic [1:0]      clk_rise;

	assign sel_code[0] = sel_ff.ch0_sel;
	assign sel_code[1] = sel_ff.ch1_sel;

	// channel 0 exponent shifts by mode
	always_comb begin
		exp0 = code_exp(sel_ff.ch0_sel);
		if (i_ch0_mode == MODE_I2C) begin
			exp0 = code_exp(sel_ff.ch0_sel) + I2C_EXTRA_SHIFT;
		end
	end
	assign exp1 = code_exp(sel_ff.ch1_sel);
	assign sel_exp[0] = exp0;
	assign sel_exp[1] = exp1;

	// both channels share one tap picker
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_tap
			assign sel_ok[ch]   = code_ok(sel_code[ch], full_rate);
			// bit n-1 of the count toggles at fxx/2^n
			assign tap_now[ch]  = presc_ff[sel_exp[ch] - 4'h1];
			assign tap_prev[ch] = presc_prev_ff[sel_exp[ch] - 4'h1];
			// prohibited codes park low rather than pick a stray tap
			assign clk_lvl[ch]  = sel_ok[ch] && tap_now[ch];
			assign clk_rise[ch] = sel_ok[ch] && fxx_en && tap_now[ch] && !tap_prev[ch];
		end
	endgenerate
	assign ok0 = sel_ok[0];
	assign ok1 = sel_ok[1];

	// tick marks the rising edge of the selected clock, one cycle wide
	always_comb begin
		nxt_clk          = '0;
		nxt_clk.ch0_clk  = clk_lvl[0];
		nxt_clk.ch0_tick = clk_rise[0];
		nxt_clk.ch1_clk  = clk_lvl[1];
		nxt_clk.ch1_tick = clk_rise[1];
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			clk_ff <= '0;
		end else if (i_ce) begin
			clk_ff <= nxt_clk;
		end
	end
	assign o_clk = clk_ff;

	// ----------------------------------------------------------------
	// pin and control fields
	// ----------------------------------------------------------------
	// internal clock drives the serial clock pin; idle high
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_sck0       <= 1'b1;
			o_sck0_oen_n <= 1'b1;
		end else if (i_ce) begin
			o_sck0       <= i_ch0_internal_clk ? nxt_clk.ch0_clk : 1'b1;
			o_sck0_oen_n <= ~i_ch0_internal_clk;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_busy_enable     <= 1'b0;
			o_ack_auto_enable <= 1'b0;
		end else if (i_ce) begin
			o_busy_enable     <= i_serial_bus_ctrl_reg[BUSY_ENABLE_BIT];
			o_ack_auto_enable <= i_serial_bus_ctrl_reg[ACK_AUTO_EN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// prohibited-setting flags
	// ----------------------------------------------------------------
	// flags only report; software must still avoid the banned codes
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ch0_prohibited <= 1'b0;
			o_ch1_prohibited <= 1'b0;
		end else if (i_ce) begin
			o_ch0_prohibited <= ~ok0;
			o_ch1_prohibited <= ~ok1;
		end
	end

endmodule

/* File: rtl/serial_clock_prescaler_select_pkg.sv */
package serial_clock_prescaler_select_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [15:0] SERIAL_CLOCK_SELECT_ADDR = 16'hFF43;
	localparam logic [7:0]  SERIAL_CLOCK_SELECT_RST  = 8'h88;

	// field positions
	localparam int CH0_SEL_LSB       = 0;
	localparam int CH1_SEL_LSB       = 4;
	localparam int BUSY_ENABLE_BIT   = 7;
	localparam int ACK_AUTO_EN_BIT   = 5;
	localparam int OSC_FULL_RATE_BIT = 0;

	// ----------------------------------------------------------------
	// code range
	// ----------------------------------------------------------------
	localparam logic [3:0] SEL_CODE_MIN = 4'h6;
	localparam logic [3:0] SEL_CODE_MAX = 4'hD;
	// i2c mode divides 2^4 more than the 2/3-wire mode for the same code
	localparam logic [3:0] I2C_EXTRA_SHIFT = 4'h4;
	localparam logic [3:0] CODE_TO_EXP_OFS = 4'h5;

	// prescaler width: largest divide is fxx/2^12; PRESC_W is 12, so the count has 13 stages
	localparam int PRESC_W = 12;

	typedef enum logic [1:0] {
		MODE_3WIRE = 2'b00,
		MODE_2WIRE = 2'b01,
		MODE_I2C   = 2'b10
	} ch0_mode_e;

	typedef struct packed {
		logic [3:0] ch1_sel;
		logic [3:0] ch0_sel;
	} clk_sel_s;

	typedef struct packed {
		logic ch1_tick;
		logic ch1_clk;
		logic ch0_tick;
		logic ch0_clk;
	} clk_out_s;

endpackage

/* File: tb/scps_asserts.sv */
`timescale 1ns/100ps
module scps_asserts (
	input wire logic                                      i_clk_sys,
	input wire logic                                      i_rstn,
	input wire logic                                      i_ce,
	input wire logic                                      i_wr,
	input wire logic                                      i_rd,
	input wire logic                                      i_ch0_internal_clk,
	input wire logic [15:0]                               i_addr,
	input wire logic [7:0]                                i_wdata,
	input wire logic [7:0]                                i_serial_bus_ctrl_reg,
	input wire logic [7:0]                                o_rdata,
	input wire logic                                      o_rd_hit,
	input wire logic                                      o_sck0,
	input wire logic                                      o_sck0_oen_n,
	input wire logic                                      o_busy_enable,
	input wire logic                                      o_ack_auto_enable,
	input wire logic                                      o_ch0_prohibited,
	input wire logic                                      o_ch1_prohibited,
	input wire serial_clock_prescaler_select_pkg::clk_out_s o_clk
);
	wire hw = i_ce && i_wr && i_addr == 16'hFF43;
	wire hr = i_ce && i_rd && i_addr == 16'hFF43;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	a_rd_answer: assert property (hr |=> o_rd_hit) else $error("no read answer");
	a_wr_back: assert property (hw ##1 !hw ##1 hr |=> o_rdata == $past(i_wdata, 3))
		else $error("readback differs");
	a_busy_copy: assert property (i_ce |=> o_busy_enable == $past(i_serial_bus_ctrl_reg[7]))
		else $error("busy enable wrong");
	a_ack_copy: assert property (i_ce |=> o_ack_auto_enable == $past(i_serial_bus_ctrl_reg[5]))
		else $error("ack enable wrong");
	a_pin_free: assert property (i_ce && !i_ch0_internal_clk |=> o_sck0 && o_sck0_oen_n)
		else $error("pin not released");
	a_pin_drive: assert property (i_ce && i_ch0_internal_clk |=> !o_sck0_oen_n)
		else $error("pin not driven");
	a_pin_follows: assert property (i_ce && i_ch0_internal_clk |=> o_sck0 == o_clk.ch0_clk)
		else $error("pin not the channel 0 clock");
	a_ch1_parked: assert property (o_ch1_prohibited |-> !o_clk.ch1_clk && !o_clk.ch1_tick)
		else $error("bad code still clocks");
	a_ch0_parked: assert property (o_ch0_prohibited |-> !o_clk.ch0_clk && !o_clk.ch0_tick)
		else $error("bad channel 0 code still clocks");
	a_tick_once: assert property (o_clk.ch0_tick |=> !o_clk.ch0_tick)
		else $error("tick too long");
	a_tick_high: assert property (o_clk.ch1_tick |-> o_clk.ch1_clk)
		else $error("tick without clock high");
	cover property (hw ##1 !hw ##1 hr);
	cover property (o_ch1_prohibited);
	cover property (o_clk.ch0_tick);
endmodule
bind serial_clock_prescaler_select scps_asserts i_chk (.*);

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
	import serial_clock_prescaler_select_pkg::*;
	localparam logic [15:0] A = SERIAL_CLOCK_SELECT_ADDR;
	logic        i_clk_sys = 1'h0, i_rstn = 1'h0, i_ce = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
	logic        i_ch0_internal_clk = 1'h1;
	logic [15:0] i_addr = 16'h0000;
	logic [7:0]  i_wdata = 8'h00, i_oscillator_mode_reg = 8'h00, i_serial_bus_ctrl_reg = 8'h00;
	ch0_mode_e   i_ch0_mode = MODE_3WIRE;
	logic [7:0]  o_rdata;
	logic        o_rd_hit, o_sck0, o_sck0_oen_n, o_busy_enable, o_ack_auto_enable;
	logic        o_ch0_prohibited, o_ch1_prohibited;
	clk_out_s    o_clk;
	int          err_total = 0, comparisons = 0;
	serial_clock_prescaler_select i_dut (.*);
	always #2.5 i_clk_sys = ~i_clk_sys;
	task automatic step(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'h1) begin
			err_total++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		step(1);
		{i_wr, i_rd, i_addr, i_wdata} = {w, ~w, a, d};
		step(1);
		{i_wr, i_rd} = 2'h0;
	endtask
	// first tick only aligns: phase after a rewrite is arbitrary
	task automatic gap(input int b, output int n);
		int k;
		for (k = 0; o_clk[b] !== 1'h1 && k < 9000; k++) step(1);
		step(1);
		for (n = 1; o_clk[b] !== 1'h1 && n < 9000; n++) step(1);
		if (k == 9000 || n == 9000) begin
			chk(1'h0, "no tick");
			end_sim;
		end
	endtask
	initial begin
		logic ill;
		int   n0, n1;
		step(10);
		i_rstn = 1'h1;
		acc(1'h0, A, 8'h00);
		chk(o_rd_hit === 1'h1 && o_rdata === 8'h88, "reset value");
		acc(1'h1, A + 16'h0001, 8'h11);
		i_ce = 1'h0;
		acc(1'h1, A, 8'h22);
		i_ce = 1'h1;
		acc(1'h1, A, 8'h3C);
		acc(1'h0, A, 8'h00);
		chk(o_rd_hit === 1'h1 && o_rdata === 8'h3C, "readback");
		$display("test access done");
		for (int i = 0; i < 6; i++) for (int c = 5; c < 15; c++) begin
			i_oscillator_mode_reg = 8'(i / 3);
			i_ch0_mode = ch0_mode_e'(i % 3);
			// rewrite only while no transfer runs
			acc(1'h1, A, {c[3:0], c[3:0]});
			ill = c < 6 || c > 13 || (c == 6 && i >= 3);
			step(3);
			chk(o_ch0_prohibited === ill && o_ch1_prohibited === ill, "bad code");
			if (!ill) begin
				gap(3, n1);
				gap(1, n0);
				chk(n1 == (2 - i / 3) << (c - 5), "ch1 rate");
				chk(n0 == n1 << (i % 3 == 2 ? 4 : 0), "ch0 rate");
			end
		end
		$display("test clock select done");
		i_serial_bus_ctrl_reg = 8'hA0;
		step(2);
		chk({o_busy_enable, o_ack_auto_enable, o_sck0_oen_n} === 3'h6, "bits set");
		i_serial_bus_ctrl_reg = 8'h5F;
		i_ch0_internal_clk = 1'h0;
		step(2);
		chk({o_busy_enable, o_ack_auto_enable, o_sck0, o_sck0_oen_n} === 4'h3, "bits clr");
		$display("test control done");
		end_sim;
	end
endmodule
